/* File: logic/acp_regs.svh */
/*
 * Constants of the converter output port and its capture logic.
 * Assumes a 100 MHz system clock; included by bare name.
 */
`ifndef ACP_REGS_SVH
`define ACP_REGS_SVH

`define ACP_WORD_W        16
`define ACP_BYTE_W        8
`define ACP_MODE_W        2
`define ACP_MODE_SSC      2'h0
`define ACP_MODE_SEC      2'h1
`define ACP_MODE_AC       2'h2
`define ACP_CHAR_BITS     11
`define ACP_FRAME_BITS    22
`define ACP_BAUD_EXP_MIN  4'h8
`define ACP_BAUD_EXP_MAX  4'hc
`define ACP_BAUD_CNT_W    12
`define ACP_RATE_EXP_MAX  4'hb
`define ACP_RATE_CNT_W    13
`define ACP_CLK_NS        10
`define ACP_SCLK_HALF_NS  500
`define ACP_SCLK_HALF_CYC (`ACP_SCLK_HALF_NS / `ACP_CLK_NS)
`define ACP_SCLK_CNT_W    8

`endif

/* File: logic/acp_pkg.sv */
/*
 * Types of the converter output port.
 * Assumes acp_regs.svh for widths.
 */
`include "acp_regs.svh"

package acp_pkg;

	typedef enum logic [3:0]
	{
		ST_IDLE = 4'h1,
		ST_SYNC = 4'h2,
		ST_UART = 4'h4,
		ST_DONE = 4'h8
	} acp_state_e;

	typedef struct packed
	{
		logic [1:0][`ACP_BYTE_W-1:0] sr;
	} acp_cap_s;

	typedef struct packed
	{
		acp_state_e                 st;
		logic [2:0]                 sync_cs;
		logic                       cs_st;
		logic [2:0]                 sync_ack;
		logic                       ack_st;
		logic [2:0]                 sync_sck;
		logic                       sck_st;
		logic [`ACP_WORD_W-1:0]     word;
		logic                       pending;
		logic                       word_ready_n;
		logic                       cts_n;
		logic                       gsel_n;
		logic [`ACP_RATE_CNT_W-1:0] rate_cnt;
		logic [`ACP_BAUD_CNT_W-1:0] baud_cnt;
		logic [`ACP_SCLK_CNT_W-1:0] sclk_cnt;
		logic                       sclk;
		logic                       sclk_oe;
		logic                       sdo;
		logic [`ACP_FRAME_BITS-1:0] tx;
		logic [4:0]                 bit_cnt;
		logic                       captured;
		logic                       flag;
		logic [`ACP_WORD_W-1:0]     par;
		logic                       par_oe;
		logic [`ACP_BYTE_W-1:0]     byte_out;
	} acp_state_s;

endpackage

/* File: logic/acp_cap_if.sv */
/*
 * Carrier between the port control and the capture shift registers.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acp_regs.svh"

interface acp_cap_if;
	logic                   shift_en;
	logic                   bit_in;
	logic [`ACP_WORD_W-1:0] word;

	modport capture (input shift_en, input bit_in, output word);
	modport control (output shift_en, output bit_in, input word);
endinterface

`default_nettype wire

/* File: logic/acp_capture.sv */
/*
 * Cascaded 8-bit capture shift registers, first bit ends in the top byte.
 * Assumes shift_en is a one-cycle pulse per serial clock rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acp_regs.svh"

module acp_capture
#(
	parameter int BYTES = 2
)
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	acp_cap_if.capture      cap
);
	acp_pkg::acp_cap_s q_ff;
	acp_pkg::acp_cap_s nxt_q;

	generate
		if (BYTES * `ACP_BYTE_W != `ACP_WORD_W)
		begin : g_chk
			$error("acp_capture: BYTES must cover the word");
		end
	endgenerate

	// Each byte feeds the next, so the pair acts as one 16-bit register
	genvar gi;
	generate
		for (gi = 0; gi < BYTES; gi++)
		begin : g_byte
			logic fill;
			if (gi == 0)
			begin : g_first
				assign fill = cap.bit_in;
			end
			else
			begin : g_next
				assign fill = q_ff.sr[gi-1][`ACP_BYTE_W-1];
			end
			always_comb
			begin
				nxt_q.sr[gi] = q_ff.sr[gi];
				if (cap.shift_en)
				begin
					nxt_q.sr[gi] = {q_ff.sr[gi][`ACP_BYTE_W-2:0], fill};
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			q_ff <= '0;
		end
		else
		begin
			q_ff <= nxt_q;
		end
	end

	assign cap.word = q_ff.sr;
endmodule // acp_capture

`default_nettype wire

/* File: logic/acp_port.sv */
/*
 * Converter serial output port with self-clocked, host-clocked and
 * character modes, rate-gated select, and parallel capture with handshake.
 * Assumes conv_word_strobe is a one-cycle pulse from logic on clk; all
 * other inputs named host_ or from jumpers are asynchronous pins.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acp_regs.svh"

// Overview of operation
// - Self-clocked mode shifts each 16-bit word into two cascaded bytes, unless a set flag locks capture.
// - Handshake flag rises toward reader whenever capture registers reload.
// - Set flag blocks further capture until host reads and acknowledges.
// - Capture proceeds only when acknowledge came since the last update.
// - Select assertion rate sets how often capture is attempted.
// - Rising gated select sets the handshake flag for a new word.
// - Byte select picks which capture byte drives the byte bus.
// - Under rate gating, select returning high marks completion; lockout bypassable.
// - Host-clocked mode presents bits at the host serial clock rate.
// - Active-low word-ready tells the host a word is waiting.
// - Character mode sends two chars: start, eight data, two stops.
// - Character bit rate from external clock, on-board source then off.
// - On-board baud divider divides clock by two to the n, n 8-12.
// - Word-ready also drives the clear-to-send output.
// - Rate gating may pace character-mode words too.
// - Self-clocked mode drives serial clock out, aligned with data bits.
// - Word-ready falls for a new word only once the last was emptied.
module acp_port
(
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic [`ACP_MODE_W-1:0]  output_mode,
	input  wire logic [`ACP_WORD_W-1:0]  conv_word,
	input  wire logic                    conv_word_strobe,
	input  wire logic                    host_output_select_n,
	input  wire logic                    host_read_ack,
	input  wire logic                    host_serial_clock_in,
	input  wire logic                    onboard_baud_source,
	input  wire logic [3:0]              baud_exp,
	input  wire logic                    rate_gate_enable,
	input  wire logic [3:0]              rate_exp,
	input  wire logic                    lockout_disable,
	input  wire logic                    byte_select,
	input  wire logic                    parallel_read_n,
	output logic                         serial_out_pin,
	output logic                         serial_clock_out,
	output logic                         serial_clock_oe,
	output logic                         converter_word_ready_n,
	output logic                         clear_to_send_n,
	output logic                         gated_select_n,
	output logic                         parallel_ready_flag,
	output logic [`ACP_WORD_W-1:0]       parallel_word,
	output logic                         parallel_oe,
	output logic [`ACP_BYTE_W-1:0]       byte_bus
);
	acp_pkg::acp_state_s q_ff;
	acp_pkg::acp_state_s nxt_q;
	acp_cap_if           cap ();

	acp_capture #(.BYTES(2)) u_capture
	(
		.clk     (clk),
		.reset_n (reset_n),
		.cap     (cap)
	);

	// Stable level once the second and third stages agree
	function automatic logic settle(input logic [2:0] s, input logic cur);
		settle = (s[2] == s[1]) ? s[2] : cur;
	endfunction

	function automatic logic [3:0] clamp_exp(input logic [3:0] e);
		if (e < `ACP_BAUD_EXP_MIN)
			clamp_exp = `ACP_BAUD_EXP_MIN;
		else if (e > `ACP_BAUD_EXP_MAX)
			clamp_exp = `ACP_BAUD_EXP_MAX;
		else
			clamp_exp = e;
	endfunction

	logic                       ack_new;
	logic                       cs_new;
	logic                       sck_new;
	logic                       sck_rise;
	logic                       sck_fall;
	logic                       baud_tick;
	logic                       bit_tick;
	logic                       load_en;
	logic                       done;
	logic                       sclk_up;
	logic [`ACP_BAUD_CNT_W-1:0] baud_mask;
	logic [`ACP_RATE_CNT_W-1:0] rate_target;
	logic [3:0]                 rexp;

	always_comb
	begin
		nxt_q = q_ff;
		done = 1'b0;
		sclk_up = 1'b0;
		cap.shift_en = 1'b0;
		cap.bit_in = q_ff.sdo;

		nxt_q.sync_cs = {q_ff.sync_cs[1:0], host_output_select_n};
		nxt_q.sync_ack = {q_ff.sync_ack[1:0], host_read_ack};
		nxt_q.sync_sck = {q_ff.sync_sck[1:0], host_serial_clock_in};
		cs_new = settle(q_ff.sync_cs, q_ff.cs_st);
		ack_new = settle(q_ff.sync_ack, q_ff.ack_st);
		sck_new = settle(q_ff.sync_sck, q_ff.sck_st);
		nxt_q.cs_st = cs_new;
		nxt_q.ack_st = ack_new;
		nxt_q.sck_st = sck_new;
		sck_rise = sck_new & ~q_ff.sck_st;
		sck_fall = ~sck_new & q_ff.sck_st;

		// Free-running divider; tick each 2^n clocks
		nxt_q.baud_cnt = q_ff.baud_cnt + 1'b1;
		baud_mask = `ACP_BAUD_CNT_W'((13'h1 << clamp_exp(baud_exp)) - 13'h1);
		baud_tick = (q_ff.baud_cnt & baud_mask) == '0;
		bit_tick = onboard_baud_source ? baud_tick : sck_rise;

		rexp = (rate_exp > `ACP_RATE_EXP_MAX) ? `ACP_RATE_EXP_MAX : rate_exp;
		rate_target = `ACP_RATE_CNT_W'(13'h2 << rexp);
		load_en = ~q_ff.flag | lockout_disable;

		// New word is taken only when the last one has gone out
		if (conv_word_strobe && !q_ff.pending)
		begin
			nxt_q.word = conv_word;
			nxt_q.pending = 1'b1;
			nxt_q.word_ready_n = 1'b0;
		end
		// Every offered word counts, so a held word cannot stall the gate
		if (conv_word_strobe && q_ff.rate_cnt != rate_target)
			nxt_q.rate_cnt = q_ff.rate_cnt + 1'b1;

		case (q_ff.st)
			acp_pkg::ST_IDLE:
			begin
				nxt_q.sclk = 1'b1;
				if (q_ff.pending && !q_ff.gsel_n)
				begin
					nxt_q.bit_cnt = '0;
					nxt_q.sclk_cnt = '0;
					if (output_mode == `ACP_MODE_AC)
					begin
						nxt_q.tx = {2'h3, q_ff.word[7:0], 1'b0,
							2'h3, q_ff.word[15:8], 1'b0};
						nxt_q.sdo = 1'b0;
						nxt_q.st = acp_pkg::ST_UART;
					end
					else
					begin
						nxt_q.sdo = q_ff.word[`ACP_WORD_W-1];
						nxt_q.tx = {6'h0, q_ff.word[`ACP_WORD_W-2:0], 1'b0};
						// Only self-clocked mode drives the clock low
						nxt_q.sclk = output_mode != `ACP_MODE_SSC;
						nxt_q.st = acp_pkg::ST_SYNC;
					end
				end
			end
			acp_pkg::ST_SYNC:
			begin
				if (output_mode == `ACP_MODE_SSC)
				begin
					// Data changes on the falling edge, stable at the rising one
					nxt_q.sclk_cnt = q_ff.sclk_cnt + 1'b1;
					if (q_ff.sclk_cnt == `ACP_SCLK_CNT_W'(`ACP_SCLK_HALF_CYC - 1))
					begin
						nxt_q.sclk_cnt = '0;
						nxt_q.sclk = ~q_ff.sclk;
						sclk_up = ~q_ff.sclk;
					end
					if (sclk_up && load_en)
					begin
						cap.shift_en = 1'b1;
						nxt_q.captured = 1'b1;
					end
				end
				else
				begin
					sclk_up = sck_rise;
				end
				if (sclk_up)
				begin
					nxt_q.bit_cnt = q_ff.bit_cnt + 1'b1;
					if (q_ff.bit_cnt == 5'(`ACP_WORD_W - 1))
						done = 1'b1;
				end
				if ((output_mode == `ACP_MODE_SSC && q_ff.sclk_cnt ==
					`ACP_SCLK_CNT_W'(`ACP_SCLK_HALF_CYC - 1) && q_ff.sclk) ||
					(output_mode != `ACP_MODE_SSC && sck_fall &&
					q_ff.bit_cnt != '0))
				begin
					nxt_q.sdo = q_ff.tx[`ACP_WORD_W-1];
					nxt_q.tx = q_ff.tx << 1;
				end
			end
			acp_pkg::ST_UART:
			begin
				if (bit_tick)
				begin
					nxt_q.tx = {1'b1, q_ff.tx[`ACP_FRAME_BITS-1:1]};
					nxt_q.sdo = q_ff.tx[1];
					nxt_q.bit_cnt = q_ff.bit_cnt + 1'b1;
					if (q_ff.bit_cnt == 5'(`ACP_FRAME_BITS - 1))
						done = 1'b1;
				end
			end
			acp_pkg::ST_DONE:
			begin
				nxt_q.st = acp_pkg::ST_IDLE;
			end
			default:
			begin
				nxt_q.st = acp_pkg::ST_IDLE;
			end
		endcase

		if (done)
		begin
			nxt_q.st = acp_pkg::ST_DONE;
			nxt_q.sdo = 1'b1;
			nxt_q.sclk = 1'b1;
			nxt_q.pending = 1'b0;
			nxt_q.word_ready_n = 1'b1;
		end
		// Host dropping select mid-word abandons it; the word stays pending
		if (q_ff.st != acp_pkg::ST_IDLE && !done && q_ff.gsel_n)
		begin
			nxt_q.st = acp_pkg::ST_IDLE;
			nxt_q.sdo = 1'b1;
		end
		nxt_q.cts_n = nxt_q.word_ready_n;

		if (rate_gate_enable)
		begin
			// Counter holds select low until the word is out
			if (done)
			begin
				nxt_q.gsel_n = 1'b1;
				nxt_q.rate_cnt = '0;
			end
			else if (q_ff.rate_cnt == rate_target && q_ff.pending)
				nxt_q.gsel_n = 1'b0;
		end
		else
		begin
			nxt_q.gsel_n = cs_new;
			nxt_q.rate_cnt = '0;
		end

		// Set beats a same-cycle acknowledge so no update is lost
		if (nxt_q.gsel_n && !q_ff.gsel_n && q_ff.captured &&
			output_mode == `ACP_MODE_SSC)
		begin
			nxt_q.flag = 1'b1;
			nxt_q.captured = 1'b0;
		end
		else if (ack_new && !q_ff.ack_st)
			nxt_q.flag = 1'b0;

		nxt_q.sclk_oe = output_mode == `ACP_MODE_SSC;
		nxt_q.par = cap.word;
		nxt_q.par_oe = ~parallel_read_n;
		nxt_q.byte_out = byte_select ? cap.word[15:8] : cap.word[7:0];
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			q_ff <= '0;
			q_ff.st <= acp_pkg::ST_IDLE;
			q_ff.sync_cs <= 3'h7;
			q_ff.cs_st <= 1'b1;
			q_ff.word_ready_n <= 1'b1;
			q_ff.cts_n <= 1'b1;
			q_ff.gsel_n <= 1'b1;
			q_ff.sclk <= 1'b1;
			q_ff.sdo <= 1'b1;
		end
		else
		begin
			q_ff <= nxt_q;
		end
	end

	assign serial_out_pin = q_ff.sdo;
	assign serial_clock_out = q_ff.sclk;
	assign serial_clock_oe = q_ff.sclk_oe;
	assign converter_word_ready_n = q_ff.word_ready_n;
	assign clear_to_send_n = q_ff.cts_n;
	assign gated_select_n = q_ff.gsel_n;
	assign parallel_ready_flag = q_ff.flag;
	assign parallel_word = q_ff.par;
	assign parallel_oe = q_ff.par_oe;
	assign byte_bus = q_ff.byte_out;
endmodule // acp_port

`default_nettype wire

/* File: verification/acp_port_assertions.sv */
/*
 * Pin-level assertions on the converter output port.
 * Assumes a bind onto acp_port and its single clk domain.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acp_regs.svh"

module acp_port_assertions
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic [1:0]  output_mode,
	input wire logic        conv_word_strobe,
	input wire logic        host_read_ack,
	input wire logic        byte_select,
	input wire logic        lockout_disable,
	input wire logic        converter_word_ready_n,
	input wire logic        clear_to_send_n,
	input wire logic        gated_select_n,
	input wire logic        parallel_ready_flag,
	input wire logic [15:0] parallel_word,
	input wire logic [7:0]  byte_bus,
	input wire logic        serial_clock_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	property p_cts;
		clear_to_send_n == converter_word_ready_n;
	endproperty
	a_cts: assert property (p_cts)
		else $error("cts differs from ready");
	property p_rdy_cause;
		$fell(converter_word_ready_n) |-> $past(conv_word_strobe);
	endproperty
	a_rdy_cause: assert property (p_rdy_cause)
		else $error("ready without new word");
	property p_rdy_hold;
		$fell(converter_word_ready_n) |=> !converter_word_ready_n[*8];
	endproperty
	a_rdy_hold: assert property (p_rdy_hold)
		else $error("ready dropped early");
	property p_flag_set;
		$rose(parallel_ready_flag) |-> gated_select_n
			&& !$past(gated_select_n, 2) && output_mode == `ACP_MODE_SSC;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("flag rose without select end");
	property p_capture;
		$changed(parallel_word) |-> !$past(gated_select_n, 2)
			&& output_mode == `ACP_MODE_SSC
			&& (!$past(parallel_ready_flag, 2) || lockout_disable);
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture moved while locked");
	property p_bytes;
		($stable(parallel_word) && $stable(byte_select))[*3] |-> byte_bus
			== (byte_select ? parallel_word[15:8] : parallel_word[7:0]);
	endproperty
	a_bytes: assert property (p_bytes)
		else $error("wrong byte on bus");
	property p_sclk_half;
		$fell(serial_clock_out) |-> ##50 $rose(serial_clock_out);
	endproperty
	a_sclk_half: assert property (p_sclk_half)
		else $error("serial clock half period wrong");
	property p_ack_needed;
		(!host_read_ack)[*8] |-> !$fell(parallel_ready_flag);
	endproperty
	a_ack_needed: assert property (p_ack_needed)
		else $error("flag cleared without ack");

	c_flag: cover property ($rose(parallel_ready_flag));
	c_word: cover property ($rose(converter_word_ready_n));
	c_bypass: cover property ($changed(parallel_word) && lockout_disable);
endmodule // acp_port_assertions

bind acp_port acp_port_assertions u_acp_chk
(
	.clk(clk), .reset_n(reset_n), .output_mode(output_mode),
	.conv_word_strobe(conv_word_strobe), .host_read_ack(host_read_ack),
	.byte_select(byte_select), .lockout_disable(lockout_disable),
	.converter_word_ready_n(converter_word_ready_n),
	.clear_to_send_n(clear_to_send_n), .gated_select_n(gated_select_n),
	.parallel_ready_flag(parallel_ready_flag),
	.parallel_word(parallel_word), .byte_bus(byte_bus),
	.serial_clock_out(serial_clock_out)
);

`default_nettype wire

/* File: verification/acp_host_model.sv */
/*
 * Host reader model: selects the port, clocks it, reads and acknowledges.
 * Assumes the port runs on the same clk; acts 1 ns after each edge.
 */
`timescale 1ns/1ns
`default_nettype none

module acp_host_model
(
	input  wire logic clk,
	input  wire logic ready_n,
	input  wire logic flag,
	input  wire logic ack_en,
	input  wire logic sclk_en,
	output logic      sel_n,
	output logic      ack,
	output logic      read_n,
	output logic      sclk
);
	initial
	begin
		sel_n = 1'b1;
		ack = 1'b0;
		read_n = 1'b1;
		sclk = 1'b1;
	end

	// Random wait gives both prompt and slow hosts
	always
	begin
		@(posedge clk);
		#1;
		if (ready_n === 1'b0)
		begin
			repeat ($urandom % 16) @(posedge clk);
			#1 sel_n = 1'b0;
			while (ready_n !== 1'b1)
			begin
				repeat (20) @(posedge clk);
				#1 sclk = sclk_en ? ~sclk : 1'b1;
			end
			@(posedge clk);
			#1 sclk = 1'b1;
			sel_n = 1'b1;
		end
	end

	// Ack only with select idle, so no word is cut
	always
	begin
		@(posedge clk);
		#1;
		if (flag === 1'b1 && ack_en && sel_n)
		begin
			read_n = 1'b0;
			repeat (3) @(posedge clk);
			#1 ack = 1'b1;
			repeat (6) @(posedge clk);
			#1 ack = 1'b0;
			read_n = 1'b1;
			repeat (8) @(posedge clk);
		end
	end
endmodule // acp_host_model

`default_nettype wire

/* File: verification/adc_serial_output_capture_port_test.sv */
/*
 * Self-checking bench for the converter output port.
 * Assumes acp_port, the host model and the bound checker.
 */
`timescale 1ns/1ns
`default_nettype none
`include "acp_regs.svh"

module adc_serial_output_capture_port_test;
	logic        clk, reset_n, strobe, obs, lockd, bsel, ack_en, sclk_en;
	logic [1:0]  mode;
	logic [3:0]  bexp;
	logic [15:0] word, w1, pword;
	logic        sel_n, ack, read_n, sclk, sdo, sco, scoe, rdy_n, cts_n;
	logic        gsel_n, flag, poe, rgate;
	logic [7:0]  bbus;
	logic [15:0] exp_q[$];
	logic        exp_b[$];
	int          num_errors = 0;
	int          n_checks = 0;

	acp_port dut
	(
		.clk(clk), .reset_n(reset_n), .output_mode(mode), .conv_word(word),
		.conv_word_strobe(strobe), .host_output_select_n(sel_n),
		.host_read_ack(ack), .host_serial_clock_in(sclk),
		.onboard_baud_source(obs), .baud_exp(bexp),
		.rate_gate_enable(rgate),
		.rate_exp(4'h0), .lockout_disable(lockd), .byte_select(bsel),
		.parallel_read_n(read_n), .serial_out_pin(sdo),
		.serial_clock_out(sco), .serial_clock_oe(scoe),
		.converter_word_ready_n(rdy_n), .clear_to_send_n(cts_n),
		.gated_select_n(gsel_n), .parallel_ready_flag(flag),
		.parallel_word(pword), .parallel_oe(poe), .byte_bus(bbus)
	);

	acp_host_model host
	(
		.clk(clk), .ready_n(rdy_n), .flag(flag), .ack_en(ack_en),
		.sclk_en(sclk_en), .sel_n(sel_n), .ack(ack), .read_n(read_n),
		.sclk(sclk)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		if (num_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Bounded wait: 0 ready, 1 flag, 2 gated select
	task automatic wait_sig(input int s, input logic v);
		int i;
		for (i = 0; i < 20000; i++)
		begin
			if ((s == 0 ? rdy_n : s == 1 ? flag : gsel_n) === v)
				return;
			@(posedge clk);
			#1;
		end
		num_errors++;
		print_verdict();
	endtask

	task automatic send(input logic [1:0] m);
		if (ack_en)
			wait_sig(1, 1'b0);
		mode = m;
		@(posedge clk);
		#1 word = 16'($urandom);
		bsel = 1'($urandom);
		if (m == `ACP_MODE_SSC && flag !== 1'b1)
		begin
			exp_q.push_back(word);
			exp_b.push_back(bsel);
		end
		strobe = 1'b1;
		@(posedge clk);
		#1 strobe = 1'b0;
		wait_sig(0, 1'b0);
		wait_sig(0, 1'b1);
		wait_sig(2, 1'b1);
	endtask

	// Compare the capture at each rise of the flag against the oldest note
	always
	begin
		@(posedge flag);
		@(posedge clk);
		#1 w1 = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
		chk(pword, w1);
		chk({8'h00, bbus}, {8'h00, exp_b.pop_front() ? w1[15:8] : w1[7:0]});
	end

	initial
	begin
		void'($urandom(59254));
		reset_n = 1'b0;
		mode = `ACP_MODE_SSC;
		word = 16'h0000;
		strobe = 1'b0;
		bexp = 4'h8;
		obs = 1'b0;
		rgate = 1'b0;
		lockd = 1'b0;
		bsel = 1'b0;
		ack_en = 1'b1;
		sclk_en = 1'b0;
		repeat (8) @(posedge clk);
		#1 chk({9'h0, sdo, sco, scoe, rdy_n, cts_n, gsel_n, flag}, 16'h006e);
		reset_n = 1'b1;
		repeat (3) send(`ACP_MODE_SSC);
		wait_sig(1, 1'b0);
		ack_en = 1'b0;
		send(`ACP_MODE_SSC);
		w1 = word;
		send(`ACP_MODE_SSC);
		chk(pword, w1);
		lockd = 1'b1;
		send(`ACP_MODE_SSC);
		w1 = word;
		chk(pword, w1);
		lockd = 1'b0;
		ack_en = 1'b1;
		wait_sig(1, 1'b0);
		rgate = 1'b1;
		@(posedge clk);
		#1 word = 16'($urandom);
		bsel = 1'($urandom);
		exp_q.push_back(word);
		exp_b.push_back(bsel);
		strobe = 1'b1;
		@(posedge clk);
		#1 strobe = 1'b0;
		repeat (8) @(posedge clk);
		#1 chk({15'h0, gsel_n}, 16'h0001);
		word = 16'($urandom);
		strobe = 1'b1;
		@(posedge clk);
		#1 strobe = 1'b0;
		wait_sig(2, 1'b0);
		wait_sig(2, 1'b1);
		rgate = 1'b0;
		wait_sig(1, 1'b0);
		sclk_en = 1'b1;
		send(`ACP_MODE_SEC);
		send(`ACP_MODE_AC);
		sclk_en = 1'b0;
		obs = 1'b1;
		send(`ACP_MODE_AC);
		chk({pword[15:1], flag}, {w1[15:1], 1'b0});
		print_verdict();
	end
endmodule // adc_serial_output_capture_port_test

`default_nettype wire
